// file: pioc_pin_model.sv
// board model of one port: pull-up on every pin, external parties only pull low
`default_nettype none
module pioc_pin_model #(
  parameter int W = 8
) (
  input wire logic [W-1:0] pin_out,
  input wire logic [W-1:0] pin_oe,
  input wire logic [W-1:0] ext_low,
  output logic [W-1:0] level
);
  timeunit 1ns;
  timeprecision 100ps;
  // wired-and: a released line goes to the pull-up level, never keeps the last value
  assign level = ~((pin_oe & ~pin_out) | ext_low);
endmodule
`default_nettype wire

// file: pioc_pkg.sv
// package: register addresses, reset values and pin positions of the port i/o block
`default_nettype none
package pioc_pkg;
  // ****************************************
  // sfr addresses
  // ****************************************
  localparam logic [7:0] ADDR_PORT0_DATA = 8'h80;
  localparam logic [7:0] ADDR_PORT2_DATA = 8'hA0;
  localparam logic [7:0] ADDR_P1_DRV_MODE = 8'hA5;
  localparam logic [7:0] ADDR_P2_DRV_MODE = 8'hA6;
  localparam logic [7:0] ADDR_P1_SKIP = 8'hD5;
  localparam logic [7:0] ADDR_P1_MATCH = 8'hED;
  localparam logic [7:0] ADDR_P1_IN_MODE = 8'hF2;
  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] RST_PORT0_DATA = 8'hFF;
  localparam logic RST_PORT2_BIT0 = 1'b1;
  localparam logic [7:0] RST_DRV_MODE = 8'h00;
  localparam logic [7:0] RST_P1_SKIP = 8'h00;
  localparam logic [7:0] RST_P1_MATCH = 8'hFF;
  localparam logic [7:0] RST_IN_MODE = 8'hFF;
  localparam logic [7:0] ZERO8 = 8'h00;
  // ****************************************
  // smbus pin positions on port 0 and peripheral output count
  // ****************************************
  localparam int SDA_PIN = 0;
  localparam int SCL_PIN = 1;
  localparam int PERIPH_OUTS = 4;
endpackage
`default_nettype wire

// file: pioc_top.sv
// port i/o block: skip masks, input and driver modes, data latches, simple crossbar
//
// Notes on behaviour
// - each port 1 pin has a skip bit; clear means the crossbar may use it, set means skipped.
// - each port 1 pin is analog or digital by its input-mode bit, never chosen automatically.
// - port 2 bit 0 is always digital and has no input-mode bit.
// - each port 1 and port 2 driver is open-drain or push-pull by its driver-mode bit, peripheral outputs too.
// - pins carrying smbus data and clock always drive open-drain.
// - writing a data register loads each bit into the pin output latch.
// - reading a data register returns the sampled pin levels of digital pins, not the latch.
// - port 0 data sits at 0x80 and is bit-addressable for single-bit set and clear.
// - port 1 skip mask resets to zero; 0 means available, 1 means skipped.
`default_nettype none
module pioc_top (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_bit_wr,
  input wire logic [2:0] sfr_bit_sel,
  input wire logic sfr_bit_val,
  output logic [7:0] sfr_rdata,
  input wire logic [7:0] port0_pin_in,
  output logic [7:0] port0_pin_out,
  output logic [7:0] port0_pin_oe,
  input wire logic [7:0] port1_pin_in,
  output logic [7:0] port1_pin_out,
  output logic [7:0] port1_pin_oe,
  input wire logic port2_pin_in,
  output logic port2_pin_out,
  output logic port2_pin_oe,
  input wire logic [7:0] port1_analog_sel_n,
  input wire logic [pioc_pkg::PERIPH_OUTS-1:0] periph_en,
  input wire logic [pioc_pkg::PERIPH_OUTS-1:0] periph_out,
  input wire logic smbus_en,
  input wire logic smbus_sda_out,
  input wire logic smbus_scl_out
);
  import pioc_pkg::*;

  // ****************************************
  // registers
  // ****************************************
  logic [7:0] p0_latch_q, p0_latch_d;
  logic p2_latch_q, p2_latch_d;
  logic [7:0] p1_drv_q, p1_drv_d;
  logic p2_drv_q, p2_drv_d;
  logic [7:0] p1_skip_q, p1_skip_d;
  logic [7:0] p1_mat_q, p1_mat_d;
  logic [7:0] p1_inmode_q, p1_inmode_d;
  logic [7:0] p1_latch_q, p1_latch_d;
  // two-flop pin synchronisers; stage one is read only by stage two
  logic [7:0] p0_s1_q, p0_s2_q, p1_s1_q, p1_s2_q;
  logic p2_s1_q, p2_s2_q;

  function automatic logic [7:0] bit_merge(input logic [7:0] v, input logic [2:0] sel,
                                           input logic b);
    logic [7:0] r;
    r = v;
    r[sel] = b;
    return r;
  endfunction

  always_comb begin
    p0_latch_d = p0_latch_q;
    p2_latch_d = p2_latch_q;
    p1_drv_d = p1_drv_q;
    p2_drv_d = p2_drv_q;
    p1_skip_d = p1_skip_q;
    p1_mat_d = p1_mat_q;
    p1_inmode_d = p1_inmode_q;
    p1_latch_d = p1_latch_q;
    if (sfr_wr) begin
      unique case (sfr_addr)
        ADDR_PORT0_DATA: p0_latch_d = sfr_wdata;
        ADDR_PORT2_DATA: p2_latch_d = sfr_wdata[0];
        ADDR_P1_DRV_MODE: p1_drv_d = sfr_wdata;
        ADDR_P2_DRV_MODE: p2_drv_d = sfr_wdata[0];
        ADDR_P1_SKIP: p1_skip_d = sfr_wdata;
        ADDR_P1_MATCH: p1_mat_d = sfr_wdata;
        ADDR_P1_IN_MODE: p1_inmode_d = sfr_wdata;
        default: ;
      endcase
    end else if (sfr_bit_wr) begin
      // single-bit set or clear touches only the selected latch bit
      if (sfr_addr == ADDR_PORT0_DATA) begin
        p0_latch_d = bit_merge(p0_latch_q, sfr_bit_sel, sfr_bit_val);
      end
      if (sfr_addr == ADDR_PORT2_DATA && sfr_bit_sel == 3'h0) begin
        p2_latch_d = sfr_bit_val;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      p0_latch_q <= RST_PORT0_DATA;
      p2_latch_q <= RST_PORT2_BIT0;
      p1_drv_q <= RST_DRV_MODE;
      p2_drv_q <= RST_DRV_MODE[0];
      p1_skip_q <= RST_P1_SKIP;
      p1_mat_q <= RST_P1_MATCH;
      p1_inmode_q <= RST_IN_MODE;
      p1_latch_q <= RST_PORT0_DATA;
      p0_s1_q <= ZERO8;
      p0_s2_q <= ZERO8;
      p1_s1_q <= ZERO8;
      p1_s2_q <= ZERO8;
      p2_s1_q <= 1'b0;
      p2_s2_q <= 1'b0;
    end else begin
      p0_latch_q <= p0_latch_d;
      p2_latch_q <= p2_latch_d;
      p1_drv_q <= p1_drv_d;
      p2_drv_q <= p2_drv_d;
      p1_skip_q <= p1_skip_d;
      p1_mat_q <= p1_mat_d;
      p1_inmode_q <= p1_inmode_d;
      p1_latch_q <= p1_latch_d;
      p0_s1_q <= port0_pin_in;
      p0_s2_q <= p0_s1_q;
      p1_s1_q <= port1_pin_in;
      p1_s2_q <= p1_s1_q;
      p2_s1_q <= port2_pin_in;
      p2_s2_q <= p2_s1_q;
    end
  end

  // ****************************************
  // read path: pin levels for port 0 and port 2 data, register values for the other mapped addresses, zero elsewhere
  // ****************************************
  always_comb begin
    unique case (sfr_addr)
      ADDR_PORT0_DATA: sfr_rdata = p0_s2_q;
      ADDR_PORT2_DATA: sfr_rdata = {7'h00, p2_s2_q};
      ADDR_P1_DRV_MODE: sfr_rdata = p1_drv_q;
      ADDR_P2_DRV_MODE: sfr_rdata = {7'h00, p2_drv_q};
      ADDR_P1_SKIP: sfr_rdata = p1_skip_q;
      ADDR_P1_MATCH: sfr_rdata = p1_mat_q;
      ADDR_P1_IN_MODE: sfr_rdata = p1_inmode_q;
      default: sfr_rdata = ZERO8;
    endcase
  end

  // ****************************************
  // crossbar on port 1: peripherals in index order take the lowest unskipped pins
  // ****************************************
  logic [7:0] p1_route_en;
  logic [7:0] p1_route_val;
  always_comb begin
    int k;
    k = 0;
    p1_route_en = ZERO8;
    p1_route_val = ZERO8;
    for (int i = 0; i < 8; i++) begin
      while (k < PERIPH_OUTS && !periph_en[k]) k++;
      if (!p1_skip_q[i] && k < PERIPH_OUTS) begin
        p1_route_en[i] = 1'b1;
        p1_route_val[i] = periph_out[k];
        k++;
      end
    end
  end

  // ****************************************
  // drivers: drive-mode bit 1 is push-pull, 0 is open-drain; analog pins float
  // ****************************************
  logic [7:0] p0_val;
  logic [7:0] p0_od_force;
  logic [7:0] p1_val;
  always_comb begin
    p0_val = p0_latch_q;
    p0_od_force = ZERO8;
    if (smbus_en) begin
      p0_val[SDA_PIN] = smbus_sda_out;
      p0_val[SCL_PIN] = smbus_scl_out;
      p0_od_force[SDA_PIN] = 1'b1;
      p0_od_force[SCL_PIN] = 1'b1;
    end
    p1_val = (p1_route_en & p1_route_val) | (~p1_route_en & p1_latch_q);
  end

  // port 0 has no mode registers in this map, so every pin, smbus pins included, is open-drain
  assign port0_pin_out = ZERO8;
  assign port0_pin_oe = ~p0_val | (p0_od_force & ~p0_val);
  assign port1_pin_out = p1_val & p1_drv_q;
  assign port1_pin_oe = p1_inmode_q & (p1_drv_q | ~p1_val);
  assign port2_pin_out = p2_latch_q & p2_drv_q;
  assign port2_pin_oe = p2_drv_q | ~p2_latch_q;

  // ****************************************
  // checks
  // ****************************************
  a_p0_write_latch: assert property (@(posedge clk) disable iff (!rst_b)
    sfr_wr && sfr_addr == ADDR_PORT0_DATA |=> p0_latch_q == $past(sfr_wdata))
    else $error("port 0 latch did not take the written byte");
  a_p0_read_pin: assert property (@(posedge clk) disable iff (!rst_b)
    sfr_addr == ADDR_PORT0_DATA |-> sfr_rdata == $past(port0_pin_in, 2))
    else $error("port 0 read is not the synchronised pin level");
  a_bit_write_one: assert property (@(posedge clk) disable iff (!rst_b)
    !sfr_wr && sfr_bit_wr && sfr_addr == ADDR_PORT0_DATA
    |=> p0_latch_q[$past(sfr_bit_sel)] == $past(sfr_bit_val))
    else $error("bit write did not reach the latch bit");
  a_smb_open_drain: assert property (@(posedge clk) disable iff (!rst_b)
    smbus_en |-> port0_pin_out[SDA_PIN] == 1'b0 && port0_pin_out[SCL_PIN] == 1'b0
      && port0_pin_oe[SDA_PIN] == !smbus_sda_out && port0_pin_oe[SCL_PIN] == !smbus_scl_out)
    else $error("smbus pin driven high or not pulled low");
  a_pp_drive: assert property (@(posedge clk) disable iff (!rst_b)
    (p1_drv_q & p1_inmode_q & ~port1_pin_oe) == ZERO8)
    else $error("push-pull digital pin not driven");
  a_analog_float: assert property (@(posedge clk) disable iff (!rst_b)
    (port1_pin_oe & ~p1_inmode_q) == ZERO8)
    else $error("analog pin is driven");
  a_od_no_high: assert property (@(posedge clk) disable iff (!rst_b)
    (port1_pin_out & ~p1_drv_q) == ZERO8)
    else $error("open-drain pin drives high");
  a_skip_kept: assert property (@(posedge clk) disable iff (!rst_b)
    (p1_route_en & p1_skip_q) == ZERO8)
    else $error("crossbar used a skipped pin");
  a_first_route: assert property (@(posedge clk) disable iff (!rst_b)
    periph_en[0] && !p1_skip_q[0] |-> p1_route_en[0] && p1_route_val[0] == periph_out[0])
    else $error("first peripheral not on lowest free pin");
  a_p2_digital: assert property (@(posedge clk) disable iff (!rst_b)
    sfr_addr == ADDR_PORT2_DATA |-> sfr_rdata[0] == $past(port2_pin_in, 2))
    else $error("port 2 bit 0 read wrong");
endmodule
`default_nettype wire

// file: tb_top.sv
// testbench of the port i/o block: registers, pin levels, drive modes, crossbar
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import pioc_pkg::*;
  logic clk = 0, rst_b = 0, wr, bwr, bval, sen, sda, scl, p2o, p2e, p2i, e2;
  logic [7:0] addr, wdata, rdata, p0o, p0e, p0i, p1o, p1e, p1i, e0, v, sk, m, dm, an;
  logic [2:0] bsel;
  logic [3:0] pen, pout;
  logic [7:0] rw_addrs [4] = '{ADDR_P1_DRV_MODE, ADDR_P1_SKIP, ADDR_P1_MATCH, ADDR_P1_IN_MODE};
  int num_errors = 0, comparisons = 0, cyc = 0;
  always #2 clk = ~clk;
  pioc_top dut (.clk(clk), .rst_b(rst_b), .sfr_addr(addr), .sfr_wr(wr), .sfr_wdata(wdata),
    .sfr_bit_wr(bwr), .sfr_bit_sel(bsel), .sfr_bit_val(bval), .sfr_rdata(rdata),
    .port0_pin_in(p0i), .port0_pin_out(p0o), .port0_pin_oe(p0e), .port1_pin_in(p1i),
    .port1_pin_out(p1o), .port1_pin_oe(p1e), .port2_pin_in(p2i), .port2_pin_out(p2o),
    .port2_pin_oe(p2e), .port1_analog_sel_n(an), .periph_en(pen), .periph_out(pout),
    .smbus_en(sen), .smbus_sda_out(sda), .smbus_scl_out(scl));
  pioc_pin_model #(.W(8)) pins0 (.pin_out(p0o), .pin_oe(p0e), .ext_low(e0), .level(p0i));
  pioc_pin_model #(.W(8)) pins1 (.pin_out(p1o), .pin_oe(p1e), .ext_low(8'h00), .level(p1i));
  pioc_pin_model #(.W(1)) pins2 (.pin_out(p2o), .pin_oe(p2e), .ext_low(e2), .level(p2i));
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1;
    @(negedge clk);
    wr = 0;
    // idle cycle so a following write never re-raises the strobe in the same step
    @(negedge clk);
  endtask
  task automatic wr_bit(input logic [7:0] a, input logic [2:0] s, input logic b);
    addr = a;
    bsel = s;
    bval = b;
    bwr = 1;
    @(negedge clk);
    bwr = 0;
    @(negedge clk);
  endtask
  task automatic rd(input string what, input logic [7:0] a, input logic [7:0] exp);
    addr = a;
    #1;
    chk(what, rdata, exp);
    // back on the falling edge before anything else is driven
    @(negedge clk);
  endtask
  // pins reach the read path through two sync flops
  task automatic settle;
    repeat (3) @(negedge clk);
  endtask
  // enabled peripherals take the lowest unskipped pins; the rest show the ff latch
  function automatic logic [7:0] xbar(input logic [7:0] s, input logic [3:0] en, po);
    logic [7:0] r;
    int j;
    r = 8'hFF;
    j = 0;
    for (int p = 0; p < PERIPH_OUTS; p++) begin
      while (en[p] && j < 8 && s[j]) j++;
      if (en[p] && j < 8) begin
        r[j] = po[p];
        j++;
      end
    end
    return r;
  endfunction
  task automatic wrap_up;
    if (num_errors == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      wrap_up();
    end
  end
  initial begin
    {addr, wdata, wr, bwr, bsel, bval, e0, e2, pen, pout, sen, sda, scl} = '0;
    v = $urandom(50);
    an = $urandom;
    repeat (2) @(negedge clk);
    rst_b = 1;
    settle();
    rd("p0 reset", ADDR_PORT0_DATA, 8'hFF);
    rd("skip reset", ADDR_P1_SKIP, 8'h00);
    rd("unmapped", 8'h81, 8'h00);
    foreach (rw_addrs[i]) begin
      v = $urandom;
      wr_reg(rw_addrs[i], v);
      rd("readback", rw_addrs[i], v);
    end
    for (int i = 0; i < 10; i++) begin
      v = (i == 0) ? 8'h00 : $urandom;
      e0 = $urandom;
      wr_reg(ADDR_PORT0_DATA, v);
      chk("p0 oe", p0e, ~v);
      chk("p0 out", p0o, 8'h00);
      settle();
      rd("p0 pins", ADDR_PORT0_DATA, v & ~e0);
    end
    e0 = 8'h00;
    wr_reg(ADDR_PORT0_DATA, 8'hFF);
    for (int i = 0; i < 8; i++) begin
      wr_bit(ADDR_PORT0_DATA, 3'(i), 1'b0);
      chk("p0 bit clear", p0e, 8'h01 << i);
      wr_bit(ADDR_PORT0_DATA, 3'(i), 1'b1);
      chk("p0 bit set", p0e, 8'h00);
    end
    sen = 1;
    for (int i = 0; i < 4; i++) begin
      {scl, sda} = 2'(i);
      @(negedge clk);
      chk("smbus oe", p0e, {6'h00, ~scl, ~sda});
      chk("smbus out", p0o, 8'h00);
    end
    sen = 0;
    wr_reg(ADDR_P2_DRV_MODE, 8'h01);
    wr_bit(ADDR_PORT2_DATA, 3'h0, 1'b0);
    chk("p2 push low", {6'h00, p2o, p2e}, 8'h01);
    wr_bit(ADDR_PORT2_DATA, 3'h0, 1'b1);
    chk("p2 push high", {6'h00, p2o, p2e}, 8'h03);
    wr_reg(ADDR_P2_DRV_MODE, 8'h00);
    chk("p2 open high", {6'h00, p2o, p2e}, 8'h00);
    settle();
    rd("p2 read", ADDR_PORT2_DATA, 8'h01);
    e2 = 1'b1;
    settle();
    rd("p2 pulled low", ADDR_PORT2_DATA, 8'h00);
    e2 = 1'b0;
    wr_reg(ADDR_PORT2_DATA, 8'hFE);
    settle();
    rd("p2 low", ADDR_PORT2_DATA, 8'h00);
    wr_reg(ADDR_P1_DRV_MODE, 8'hFF);
    for (int i = 0; i < 20; i++) begin
      sk = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : $urandom;
      m = (i < 2) ? 8'hFF : $urandom;
      dm = (i < 2) ? 8'hFF : $urandom;
      pen = (i < 2) ? 4'hF : $urandom;
      pout = $urandom;
      wr_reg(ADDR_P1_SKIP, sk);
      wr_reg(ADDR_P1_IN_MODE, m);
      wr_reg(ADDR_P1_DRV_MODE, dm);
      // push-pull drives always, open-drain only pulls low, analog never drives
      v = xbar(sk, pen, pout);
      chk("p1 oe", p1e, m & (dm | ~v));
      chk("p1 out", p1o & m, v & dm & m);
    end
    wrap_up();
  end
endmodule
`default_nettype wire
